// ### hdl/cpu_regset.sv
// CPU architectural register set with fast interrupt backup
`timescale 1ns/10ps
`default_nettype none

module cpu_regset import regset_pkg::*; #(
  parameter int NUM_GPR = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // General register ports
  input  wire logic [IDX_W-1:0] gpr_rd_a_idx,
  input  wire logic [IDX_W-1:0] gpr_rd_b_idx,
  input  wire gpr_wr_t          gpr_wr,
  output var  logic [XLEN-1:0]  gpr_rd_a_data,
  output var  logic [XLEN-1:0]  gpr_rd_b_data,
  // Control register ports
  input  wire ctl_wr_t          ctl_wr,
  input  wire ctl_sel_t         ctl_rd_sel,
  output var  logic [XLEN-1:0]  ctl_rd_data,
  // Sequencing
  input  wire logic             pc_load,
  input  wire logic [XLEN-1:0]  pc_next,
  input  wire flag_upd_t        flag_upd,
  input  wire logic             fast_irq_take,
  input  wire logic             vec_req,
  input  wire logic [VEC_W-1:0] vec_num,
  output var  logic [XLEN-1:0]  program_counter,
  output var  logic [XLEN-1:0]  processor_status_word,
  output var  logic [XLEN-1:0]  vec_addr,
  // Accumulator
  input  wire acc_op_t          acc_op,
  input  wire logic [XLEN-1:0]  acc_opnd_a,
  input  wire logic [XLEN-1:0]  acc_opnd_b,
  input  wire logic             acc_rd_req,
  input  wire logic             acc_rd_mid,
  output var  logic [XLEN-1:0]  acc_rd_data,
  // AXI4-Lite slave
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output var  logic             awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output var  logic             wready,
  output var  logic [1:0]       bresp,
  output var  logic             bvalid,
  input  wire logic             bready,
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output var  logic             arready,
  output var  logic [31:0]      rdata,
  output var  logic [1:0]       rresp,
  output var  logic             rvalid,
  input  wire logic             rready
);

  if (NUM_GPR < 2 || NUM_GPR > 16) begin : g_bad_num
    $error("NUM_GPR must lie in 2..16");
  end

  // ==========================================================
  // State
  logic [XLEN-1:0]  gpr_q [1:NUM_GPR-1];
  logic [XLEN-1:0]  isp_q, usp_q, vtb_q, fiv_q, pc_q, psw_q, bpc_q, fast_irq_saved_status_q;
  logic [ACC_W-1:0] acc_q;
  logic [XLEN-1:0]  sp_act;
  logic             aw_have_q, w_have_q;
  logic [7:0]       aw_addr_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;
  logic             axi_wr_go;
  logic [31:0]      axi_rmux;
  logic             axi_rerr;
  logic [ACC_W-1:0] prod_s, prod_u;

  assign sp_act    = psw_q[PSW_U_BIT] ? usp_q : isp_q;
  assign axi_wr_go = aw_have_q && w_have_q && !bvalid;

  function automatic logic [XLEN-1:0] gpr_read(input logic [IDX_W-1:0] idx,
                                                input logic [XLEN-1:0] sp);
    logic [XLEN-1:0] v;
    v = '0;
    if (idx == '0) begin
      v = sp;
    end else if (32'(idx) < NUM_GPR) begin
      v = gpr_q[idx];
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // General registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 1; i < NUM_GPR; i++) begin
        gpr_q[i] <= REG_RST;
      end
    end else if (gpr_wr.en && gpr_wr.idx != '0 && 32'(gpr_wr.idx) < NUM_GPR) begin
      gpr_q[gpr_wr.idx] <= gpr_wr.data;
    end
  end

  // Stack pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isp_q <= REG_RST;
      usp_q <= REG_RST;
    end else begin
      if (ctl_wr.en && ctl_wr.sel == CTL_ISP) begin
        isp_q <= ctl_wr.data;
      end else if (gpr_wr.en && gpr_wr.idx == '0 && !psw_q[PSW_U_BIT]) begin
        isp_q <= gpr_wr.data;
      end
      if (ctl_wr.en && ctl_wr.sel == CTL_USP) begin
        usp_q <= ctl_wr.data;
      end else if (gpr_wr.en && gpr_wr.idx == '0 && psw_q[PSW_U_BIT]) begin
        usp_q <= gpr_wr.data;
      end
    end
  end

  // Register read ports, registered from current state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpr_rd_a_data <= '0;
      gpr_rd_b_data <= '0;
      ctl_rd_data   <= '0;
    end else begin
      gpr_rd_a_data <= gpr_read(gpr_rd_a_idx, sp_act);
      gpr_rd_b_data <= gpr_read(gpr_rd_b_idx, sp_act);
      case (ctl_rd_sel)
        CTL_ISP:  ctl_rd_data <= isp_q;
        CTL_USP:  ctl_rd_data <= usp_q;
        CTL_VTB:  ctl_rd_data <= vtb_q;
        CTL_PSW:  ctl_rd_data <= psw_q;
        CTL_BPC:  ctl_rd_data <= bpc_q;
        CTL_FAST_IRQ_SAVED_STATUS: ctl_rd_data <= fast_irq_saved_status_q;
        CTL_FIV:  ctl_rd_data <= fiv_q;
        default:  ctl_rd_data <= '0;
      endcase
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vtb_q <= VTB_RST;
      fiv_q <= FIV_RST;
    end else begin
      if (ctl_wr.en && ctl_wr.sel == CTL_VTB) begin
        vtb_q <= ctl_wr.data;
      end else if (axi_wr_go && aw_addr_q == OFS_VTB) begin
        vtb_q <= merge(vtb_q, w_data_q, w_strb_q);
      end
      if (ctl_wr.en && ctl_wr.sel == CTL_FIV) begin
        fiv_q <= ctl_wr.data;
      end else if (axi_wr_go && aw_addr_q == OFS_FIV) begin
        fiv_q <= merge(fiv_q, w_data_q, w_strb_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= PC_RST;
    end else if (fast_irq_take) begin
      pc_q <= fiv_q;
    end else if (pc_load) begin
      pc_q <= pc_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psw_q <= PSW_RST;
    end else if (ctl_wr.en && ctl_wr.sel == CTL_PSW) begin
      psw_q <= ctl_wr.data;
    end else if (flag_upd.en) begin
      psw_q[PSW_O_BIT:PSW_C_BIT] <= flag_upd.flags;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bpc_q  <= REG_RST;
      fast_irq_saved_status_q <= PSW_RST;
    end else if (fast_irq_take) begin
      bpc_q  <= pc_q;
      fast_irq_saved_status_q <= psw_q;
    end else if (ctl_wr.en && ctl_wr.sel == CTL_BPC) begin
      bpc_q <= ctl_wr.data;
    end else if (ctl_wr.en && ctl_wr.sel == CTL_FAST_IRQ_SAVED_STATUS) begin
      fast_irq_saved_status_q <= ctl_wr.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_addr <= '0;
    end else if (vec_req) begin
      vec_addr <= vtb_q + {22'h0, vec_num, 2'b00};
    end
  end

  assign program_counter       = pc_q;
  assign processor_status_word = psw_q;

  // ==========================================================
  // Accumulator
  assign prod_s = $signed({{32{acc_opnd_a[31]}}, acc_opnd_a}) * $signed({{32{acc_opnd_b[31]}}, acc_opnd_b});
  assign prod_u = {32'h0, acc_opnd_a} * {32'h0, acc_opnd_b};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= ACC_RST;
    end else begin
      case (acc_op)
        ACC_NONE:    acc_q <= acc_q;
        ACC_WR_HIGH: acc_q[63:32] <= acc_opnd_a;
        ACC_WR_LOW:  acc_q[31:0] <= acc_opnd_a;
        ACC_EXTENDED_MULTIPLY_SIGNED_S:  acc_q <= prod_s;
        ACC_EXTENDED_MULTIPLY_SIGNED_U:  acc_q <= prod_u;
        ACC_MUL:     acc_q <= prod_s;
        ACC_REPEAT_MULTIPLY_ACCUMULATE:    acc_q <= acc_q + prod_s;
        default:     acc_q <= acc_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_rd_data <= '0;
    end else if (acc_rd_req) begin
      acc_rd_data <= acc_rd_mid ? acc_q[ACC_MID_LO +: 32] : acc_q[63:32];
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      awready <= !aw_have_q && !(awvalid && awready) && !bvalid;
      wready  <= !w_have_q && !(wvalid && wready) && !bvalid;
      if (axi_wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (aw_addr_q == OFS_VTB || aw_addr_q == OFS_FIV) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_comb begin
    axi_rerr = 1'b0;
    case (araddr)
      OFS_VTB:       axi_rmux = vtb_q;
      OFS_FIV:       axi_rmux = fiv_q;
      OFS_PC:        axi_rmux = pc_q;
      OFS_PSW:       axi_rmux = psw_q;
      OFS_SAVED_PC:  axi_rmux = bpc_q;
      OFS_SAVED_PSW: axi_rmux = fast_irq_saved_status_q;
      OFS_SP:        axi_rmux = sp_act;
      default: begin
        axi_rmux = '0;
        axi_rerr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= axi_rmux;
      rresp   <= axi_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sp_isp: assert property (gpr_rd_a_idx == '0 && !psw_q[PSW_U_BIT] |=> gpr_rd_a_data == $past(isp_q))
    else $error("stack read not from interrupt pointer");
  chk_sp_usp: assert property (gpr_rd_b_idx == '0 && psw_q[PSW_U_BIT] |=> gpr_rd_b_data == $past(usp_q))
    else $error("stack read not from user pointer");
  chk_fast_pc: assert property (fast_irq_take |=> bpc_q == $past(pc_q))
    else $error("backup counter not saved");
  chk_fast_psw: assert property (fast_irq_take |=> fast_irq_saved_status_q == $past(psw_q))
    else $error("backup status not saved");
  chk_fast_branch: assert property (fast_irq_take |=> pc_q == $past(fiv_q))
    else $error("fast branch target wrong");
  chk_acc_high: assert property (acc_op == ACC_WR_HIGH |=>
    acc_q[63:32] == $past(acc_opnd_a) && acc_q[31:0] == $past(acc_q[31:0]))
    else $error("accumulator high write wrong");
  chk_acc_mid: assert property (acc_rd_req && acc_rd_mid |=> acc_rd_data == $past(acc_q[47:16]))
    else $error("accumulator middle read wrong");
  chk_acc_umul: assert property (acc_op == ACC_EXTENDED_MULTIPLY_SIGNED_U |=>
    acc_q == {32'h0, $past(acc_opnd_a)} * {32'h0, $past(acc_opnd_b)})
    else $error("unsigned multiply result wrong");
  chk_wr_then_rd: assert property (gpr_wr.en && gpr_wr.idx != '0 && !ctl_wr.en
    ##1 gpr_rd_a_idx == $past(gpr_wr.idx) |=> gpr_rd_a_data == $past(gpr_wr.data, 2))
    else $error("written value not seen by next read");
  chk_vec_addr: assert property (vec_req |=> vec_addr == $past(vtb_q) + {22'h0, $past(vec_num), 2'b00})
    else $error("vector address wrong");
  chk_flags: assert property (flag_upd.en && !ctl_wr.en |=> psw_q[3:0] == $past(flag_upd.flags))
    else $error("flags not updated");

  cov_fast_irq: cover property (pc_load ##1 fast_irq_take ##1 pc_q == fiv_q);
  cov_user_stack: cover property (psw_q[PSW_U_BIT] && gpr_wr.en && gpr_wr.idx == '0);
  cov_repeat_multiply_accumulate_pair: cover property (acc_op == ACC_REPEAT_MULTIPLY_ACCUMULATE ##1 acc_op == ACC_REPEAT_MULTIPLY_ACCUMULATE);
  cov_axi_rw: cover property (bvalid && bready ##[1:4] rvalid && rready);

endmodule

`default_nettype wire

// ### hdl/regset_pkg.sv
// Shared constants and types for the CPU register set
package regset_pkg;

  // ==========================================================
  // Widths
  localparam int XLEN       = 32;
  localparam int ACC_W      = 64;
  localparam int IDX_W      = 4;
  localparam int VEC_W      = 8;
  localparam int VEC_SHIFT  = 2;
  localparam int ACC_MID_LO = 16;

  // ==========================================================
  // Status word field positions
  localparam int PSW_C_BIT = 0;
  localparam int PSW_Z_BIT = 1;
  localparam int PSW_S_BIT = 2;
  localparam int PSW_O_BIT = 3;
  localparam int PSW_U_BIT = 17;

  // ==========================================================
  // Reset values
  localparam logic [31:0] PSW_RST = 32'h0000_0000;
  localparam logic [31:0] PC_RST  = 32'h0000_0000;
  localparam logic [31:0] VTB_RST = 32'h0000_0000;
  localparam logic [31:0] FIV_RST = 32'h0000_0000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [63:0] ACC_RST = 64'h0;

  // ==========================================================
  // Register bus map (byte offsets)
  localparam logic [7:0] OFS_VTB       = 8'h00;
  localparam logic [7:0] OFS_FIV       = 8'h04;
  localparam logic [7:0] OFS_PC        = 8'h08;
  localparam logic [7:0] OFS_PSW       = 8'h0c;
  localparam logic [7:0] OFS_SAVED_PC  = 8'h10;
  localparam logic [7:0] OFS_SAVED_PSW = 8'h14;
  localparam logic [7:0] OFS_SP        = 8'h18;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;

  // ==========================================================
  // Commands
  typedef enum logic [6:0] {
    ACC_NONE     = 7'b000_0001,
    ACC_WR_HIGH  = 7'b000_0010,
    ACC_WR_LOW   = 7'b000_0100,
    ACC_EXTENDED_MULTIPLY_SIGNED_S   = 7'b000_1000,
    ACC_EXTENDED_MULTIPLY_SIGNED_U   = 7'b001_0000,
    ACC_MUL      = 7'b010_0000,
    ACC_REPEAT_MULTIPLY_ACCUMULATE     = 7'b100_0000
  } acc_op_t;

  typedef enum logic [2:0] {
    CTL_ISP  = 3'h0,
    CTL_USP  = 3'h1,
    CTL_VTB  = 3'h2,
    CTL_PSW  = 3'h3,
    CTL_BPC  = 3'h4,
    CTL_FAST_IRQ_SAVED_STATUS = 3'h5,
    CTL_FIV  = 3'h6
  } ctl_sel_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [XLEN-1:0]  data;
  } gpr_wr_t;

  typedef struct packed {
    logic            en;
    ctl_sel_t        sel;
    logic [XLEN-1:0] data;
  } ctl_wr_t;

  typedef struct packed {
    logic       en;
    logic [3:0] flags;
  } flag_upd_t;

endpackage

// ### verification/exec_model.sv
// Execution-side model driving the register set pipeline ports
`timescale 1ns/10ps
`default_nettype none
module exec_model import regset_pkg::*; (
  // Clock
  input  wire logic             aclk,
  // Register writes
  output var  gpr_wr_t          gpr_wr,
  output var  ctl_wr_t          ctl_wr,
  // Sequencing
  output var  logic             pc_load,
  output var  logic [XLEN-1:0]  pc_next,
  output var  flag_upd_t        flag_upd,
  output var  logic             fast_irq_take,
  output var  logic             vec_req,
  output var  logic [VEC_W-1:0] vec_num,
  // Accumulator
  output var  acc_op_t          acc_op,
  output var  logic [XLEN-1:0]  acc_opnd_a,
  output var  logic [XLEN-1:0]  acc_opnd_b,
  output var  logic             acc_rd_req,
  output var  logic             acc_rd_mid
);
  initial begin
    gpr_wr = '0;
    ctl_wr = '{en: 1'b0, sel: CTL_ISP, data: '0};
    {pc_load, pc_next, fast_irq_take, vec_req, vec_num} = '0;
    flag_upd = '0;
    acc_op = ACC_NONE;
    {acc_opnd_a, acc_opnd_b, acc_rd_req, acc_rd_mid} = '0;
  end
  // ==========================================================
  // Ends every request one cycle after it was raised
  task automatic done();
    @(posedge aclk);
    gpr_wr.en <= 1'b0;
    ctl_wr.en <= 1'b0;
    {pc_load, fast_irq_take, vec_req, acc_rd_req} <= '0;
    flag_upd.en <= 1'b0;
    acc_op <= ACC_NONE;
    #1;
  endtask
  task automatic gpr_put(input logic [3:0] i, input logic [31:0] d);
    @(posedge aclk);
    gpr_wr <= '{en: 1'b1, idx: i, data: d};
    done();
  endtask
  task automatic ctl_put(input ctl_sel_t s, input logic [31:0] d);
    @(posedge aclk);
    ctl_wr <= '{en: 1'b1, sel: s, data: d};
    done();
  endtask
  task automatic counter_put(input logic [31:0] d);
    @(posedge aclk);
    pc_load <= 1'b1;
    pc_next <= d;
    done();
  endtask
  task automatic flags_put(input logic [3:0] f);
    @(posedge aclk);
    flag_upd <= '{en: 1'b1, flags: f};
    done();
  endtask
  task automatic fast_irq();
    @(posedge aclk);
    fast_irq_take <= 1'b1;
    done();
  endtask
  task automatic vec_ask(input logic [7:0] n);
    @(posedge aclk);
    vec_req <= 1'b1;
    vec_num <= n;
    done();
  endtask
  task automatic accum_do(input acc_op_t op, input logic [31:0] a, input logic [31:0] b);
    @(posedge aclk);
    acc_op <= op;
    acc_opnd_a <= a;
    acc_opnd_b <= b;
    done();
  endtask
  task automatic accum_ask(input logic mid);
    @(posedge aclk);
    acc_rd_req <= 1'b1;
    acc_rd_mid <= mid;
    done();
  endtask
endmodule
`default_nettype wire

// ### verification/test_cpu_register_set_with_fast_irq_backup.sv
// Self-checking bench for the CPU register set
`timescale 1ns/10ps
`default_nettype none
module test_cpu_register_set_with_fast_irq_backup import regset_pkg::*; ();
  logic             aclk = 1'b0, aresetn = 1'b0;
  logic [IDX_W-1:0] gpr_rd_a_idx, gpr_rd_b_idx;
  ctl_sel_t         ctl_rd_sel;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata;
  logic [3:0]       wstrb;
  logic             awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp;
  gpr_wr_t          gpr_wr;
  ctl_wr_t          ctl_wr;
  flag_upd_t        flag_upd;
  acc_op_t          acc_op;
  logic             pc_load, fast_irq_take, vec_req, acc_rd_req, acc_rd_mid;
  logic [VEC_W-1:0] vec_num;
  logic [XLEN-1:0]  pc_next, acc_opnd_a, acc_opnd_b, gpr_rd_a_data, gpr_rd_b_data;
  logic [XLEN-1:0]  ctl_rd_data, program_counter, processor_status_word, vec_addr, acc_rd_data;
  int               error_cnt = 0, n_tests = 0;

  cpu_regset #(.NUM_GPR(16)) cpu_regset_inst (
    .aclk(aclk), .aresetn(aresetn),
    .gpr_rd_a_idx(gpr_rd_a_idx), .gpr_rd_b_idx(gpr_rd_b_idx), .gpr_wr(gpr_wr),
    .gpr_rd_a_data(gpr_rd_a_data), .gpr_rd_b_data(gpr_rd_b_data),
    .ctl_wr(ctl_wr), .ctl_rd_sel(ctl_rd_sel), .ctl_rd_data(ctl_rd_data),
    .pc_load(pc_load), .pc_next(pc_next), .flag_upd(flag_upd), .fast_irq_take(fast_irq_take),
    .vec_req(vec_req), .vec_num(vec_num), .program_counter(program_counter),
    .processor_status_word(processor_status_word), .vec_addr(vec_addr),
    .acc_op(acc_op), .acc_opnd_a(acc_opnd_a), .acc_opnd_b(acc_opnd_b),
    .acc_rd_req(acc_rd_req), .acc_rd_mid(acc_rd_mid), .acc_rd_data(acc_rd_data),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );
  exec_model exec_model_inst (
    .aclk(aclk), .gpr_wr(gpr_wr), .ctl_wr(ctl_wr), .pc_load(pc_load), .pc_next(pc_next),
    .flag_upd(flag_upd), .fast_irq_take(fast_irq_take), .vec_req(vec_req), .vec_num(vec_num),
    .acc_op(acc_op), .acc_opnd_a(acc_opnd_a), .acc_opnd_b(acc_opnd_b),
    .acc_rd_req(acc_rd_req), .acc_rd_mid(acc_rd_mid)
  );

  always #50 aclk = ~aclk;
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [3:0] i, input logic [3:0] j);
    @(posedge aclk);
    gpr_rd_a_idx <= i;
    gpr_rd_b_idx <= j;
    @(posedge aclk);
    #1;
  endtask
  task automatic crd(input ctl_sel_t s);
    @(posedge aclk);
    ctl_rd_sel <= s;
    @(posedge aclk);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic pa, pw, pb;
    {pa, pw, pb} = 3'b111;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'b111;
    while (pa | pw | pb) begin
      @(posedge aclk);
      if (!pa && !pw && bvalid) begin
        bready <= 1'b0;
        pb = 1'b0;
        chk(bresp, er);
      end
      if (pa && awready) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic p, q;
    {p, q} = 2'b11;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (p | q) begin
      @(posedge aclk);
      if (!p && rvalid) begin
        rready <= 1'b0;
        q = 1'b0;
        chk(rdata, exp);
        chk(rresp, er);
      end
      if (p && arready) begin
        arvalid <= 1'b0;
        p = 1'b0;
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_gpr();
    for (int i = 0; i < 16; i++) begin
      fork
        exec_model_inst.gpr_put(4'(i), 32'h100 * i + 32'h4);
        begin
          repeat (2) @(posedge aclk);
          gpr_rd_a_idx <= 4'(i);
        end
      join
      @(posedge aclk);
      #1;
      chk(gpr_rd_a_data, 32'h100 * i + 32'h4);
    end
    for (int i = 0; i < 16; i++) begin
      rd(4'(i), 4'(15 - i));
      chk(gpr_rd_b_data, 32'h100 * (15 - i) + 32'h4);
    end
  endtask
  task automatic t_stack();
    exec_model_inst.ctl_put(CTL_USP, 32'h2000);
    crd(CTL_ISP);
    chk(ctl_rd_data, 32'h4);
    exec_model_inst.ctl_put(CTL_PSW, 32'h2_0000);
    rd(4'h0, 4'h0);
    chk(gpr_rd_a_data, 32'h2000);
    chk(gpr_rd_b_data, 32'h2000);
    exec_model_inst.gpr_put(4'h0, 32'h3000);
    crd(CTL_USP);
    chk(ctl_rd_data, 32'h3000);
    axi_rd(OFS_SP, 32'h3000, RESP_OKAY);
    crd(CTL_ISP);
    chk(ctl_rd_data, 32'h4);
  endtask
  task automatic t_fast();
    exec_model_inst.counter_put(32'h1230);
    exec_model_inst.flags_put(4'h5);
    chk(program_counter, 32'h1230);
    chk(processor_status_word, 32'h2_0005);
    axi_wr(OFS_FIV, 32'h5000_0000, 4'hf, RESP_OKAY);
    axi_wr(OFS_FIV, 32'h1111_11ff, 4'h1, RESP_OKAY);
    exec_model_inst.fast_irq();
    chk(program_counter, 32'h5000_00ff);
    crd(CTL_BPC);
    chk(ctl_rd_data, 32'h1230);
    crd(CTL_FAST_IRQ_SAVED_STATUS);
    chk(ctl_rd_data, 32'h2_0005);
    axi_rd(OFS_SAVED_PC, 32'h1230, RESP_OKAY);
    axi_rd(OFS_PC, 32'h5000_00ff, RESP_OKAY);
    axi_rd(OFS_SAVED_PSW, 32'h2_0005, RESP_OKAY);
    axi_rd(OFS_FIV, 32'h5000_00ff, RESP_OKAY);
    axi_rd(OFS_PSW, 32'h2_0005, RESP_OKAY);
    exec_model_inst.ctl_put(CTL_BPC, 32'h40);
    crd(CTL_BPC);
    chk(ctl_rd_data, 32'h40);
  endtask
  task automatic t_vec();
    axi_wr(OFS_VTB, 32'h8000, 4'hf, RESP_OKAY);
    axi_rd(OFS_VTB, 32'h8000, RESP_OKAY);
    exec_model_inst.vec_ask(8'h03);
    chk(vec_addr, 32'h800c);
    exec_model_inst.vec_ask(8'hff);
    chk(vec_addr, 32'h83fc);
    exec_model_inst.ctl_put(CTL_VTB, 32'h4000);
    crd(CTL_VTB);
    chk(ctl_rd_data, 32'h4000);
    exec_model_inst.vec_ask(8'h01);
    chk(vec_addr, 32'h4004);
    exec_model_inst.ctl_put(CTL_FIV, 32'h6000);
    crd(CTL_FIV);
    chk(ctl_rd_data, 32'h6000);
    axi_wr(OFS_PC, 32'h1, 4'hf, RESP_SLVERR);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_acc();
    exec_model_inst.accum_do(ACC_WR_HIGH, 32'h1234_5678, 32'h0);
    exec_model_inst.accum_do(ACC_WR_LOW, 32'h9abc_def0, 32'h0);
    exec_model_inst.accum_ask(1'b0);
    chk(acc_rd_data, 32'h1234_5678);
    exec_model_inst.accum_ask(1'b1);
    chk(acc_rd_data, 32'h5678_9abc);
    exec_model_inst.accum_do(ACC_MUL, 32'h1_0000, 32'h1_0000);
    exec_model_inst.accum_ask(1'b1);
    chk(acc_rd_data, 32'h0001_0000);
    exec_model_inst.accum_do(ACC_WR_LOW, 32'hffff_ffff, 32'h0);
    exec_model_inst.accum_ask(1'b1);
    chk(acc_rd_data, 32'h0001_ffff);
    exec_model_inst.accum_do(ACC_EXTENDED_MULTIPLY_SIGNED_U, 32'hffff_ffff, 32'h2);
    exec_model_inst.accum_ask(1'b0);
    chk(acc_rd_data, 32'h1);
    exec_model_inst.accum_do(ACC_EXTENDED_MULTIPLY_SIGNED_S, 32'hffff_ffff, 32'h2);
    exec_model_inst.accum_ask(1'b0);
    chk(acc_rd_data, 32'hffff_ffff);
    exec_model_inst.accum_do(ACC_REPEAT_MULTIPLY_ACCUMULATE, 32'h1_0000, 32'h1_0000);
    exec_model_inst.accum_ask(1'b1);
    chk(acc_rd_data, 32'h0000_ffff);
  endtask
  // ==========================================================
  // Verdict
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {gpr_rd_a_idx, gpr_rd_b_idx, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    ctl_rd_sel = CTL_ISP;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(program_counter, 32'h0);
    chk(processor_status_word, 32'h0);
    t_gpr();
    t_stack();
    t_fast();
    t_vec();
    t_acc();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
